// ==== rtl/spbc_regs.v ====
// Purpose: bridge control upper half, express capability header and device
//          capabilities registers of one switch port, on a classic wishbone slave
// Assumes: single clock, synchronous active high reset, 32-bit data bus
// Notes:   every access is acked one cycle after it is seen; unmapped reads return zero
`timescale 1ns/1ps
`include "spbc_map.vh"
module spbc_regs #(
    parameter UPSTREAM = 0,
    parameter AW       = 8
) (
    input  wire          clk_i,
    input  wire          rst_i,
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [AW-1:0] wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    input  wire          req_valid_i,
    input  wire          req_is_io_i,
    input  wire [31:0]   req_addr_i,
    output reg           video_hit_o,
    output reg           video_hit_valid_o,
    output reg           legacy_video_forward_o,
    output reg           legacy_video_wide_decode_o,
    output reg           sbr_upstream_o,
    output reg           sbr_downstream_o,
    output reg           sbr_start_o
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // merge write data into a word under the byte lane enables
    function [31:0] spbc_merge;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0]  sel;
        integer      i;
        begin
            spbc_merge = old_word;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    spbc_merge[i*8 +: 8] = new_word[i*8 +: 8];
                end
            end
        end
    endfunction

    // compare a bus address against a register offset, word granular
    function spbc_hit;
        input [AW-1:0] adr;
        input [7:0]    offset;
        begin
            spbc_hit = (adr[AW-1:2] == offset[AW-1:2]);
        end
    endfunction

    // ------------------------------------------------------------------
    // software visible state
    // ------------------------------------------------------------------
    reg        video_fwd_reg;
    reg        video_wide_reg;
    reg        sbr_reg;
    reg [7:0]  next_ptr_reg;
    reg [3:0]  cap_ver_reg;
    reg        slot_reg;
    reg [2:0]  max_payload_reg;
    reg        ext_tag_reg;
    reg        lock_open_reg;
    reg        unmapped_seen_reg;
    reg        locked_write_seen_reg;

    reg        video_fwd_next;
    reg        video_wide_next;
    reg        sbr_next;
    reg [7:0]  next_ptr_next;
    reg [3:0]  cap_ver_next;
    reg        slot_next;
    reg [2:0]  max_payload_next;
    reg        ext_tag_next;
    reg        lock_open_next;
    reg        unmapped_seen_next;
    reg        locked_write_seen_next;

    // ------------------------------------------------------------------
    // read images
    // ------------------------------------------------------------------
    wire [31:0] bridge_word;
    wire [31:0] cap_hdr_word;
    wire [31:0] dev_cap_word;
    wire [31:0] lock_word;
    wire [31:0] status_word;
    wire [3:0]  port_type;

    assign port_type = (UPSTREAM != 0) ? `SPBC_TYPE_UP : `SPBC_TYPE_DOWN;

    // only bits 3, 4 and 6 exist; bit 5 and 15:7 stay zero
    assign bridge_word = {25'h000_0000,
                          sbr_reg,
                          1'b0,
                          video_wide_reg,
                          video_fwd_reg,
                          3'h0};

    // 31:30 reserved and 29:25 message number both read zero
    assign cap_hdr_word = {2'h0,
                           5'h00,
                           slot_reg,
                           port_type,
                           cap_ver_reg,
                           next_ptr_reg,
                           `SPBC_CAP_ID};

    // fields above 17 belong to a neighbouring block and read zero here
    assign dev_cap_word = {16'h0000,
                           1'b1,
                           3'h0,
                           3'h0,
                           3'h0,
                           ext_tag_reg,
                           2'h0,
                           max_payload_reg};

    assign lock_word   = {31'h0000_0000, lock_open_reg};
    assign status_word = {27'h000_0000,
                          locked_write_seen_reg,
                          unmapped_seen_reg,
                          lock_open_reg,
                          (UPSTREAM != 0),
                          sbr_reg};

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire        bus_req;
    wire        bus_wr;
    wire        sel_bridge;
    wire        sel_cap_hdr;
    wire        sel_dev_cap;
    wire        sel_lock;
    wire        sel_status;
    wire        sel_any;
    wire [31:0] wr_bridge;
    wire [31:0] wr_cap_hdr;
    wire [31:0] wr_dev_cap;
    wire [31:0] wr_lock;
    wire [31:0] wr_status;

    // a request is taken once; the registered ack keeps a held request from repeating
    assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_wr      = bus_req & wb_we_i;
    assign sel_bridge  = spbc_hit(wb_adr_i, `SPBC_ADR_BRIDGE);
    assign sel_cap_hdr = spbc_hit(wb_adr_i, `SPBC_ADR_CAP_HDR);
    assign sel_dev_cap = spbc_hit(wb_adr_i, `SPBC_ADR_DEV_CAP);
    assign sel_lock    = spbc_hit(wb_adr_i, `SPBC_ADR_LOCK);
    assign sel_status  = spbc_hit(wb_adr_i, `SPBC_ADR_STATUS);
    assign sel_any     = sel_bridge | sel_cap_hdr | sel_dev_cap | sel_lock | sel_status;

    assign wr_bridge  = spbc_merge(bridge_word, wb_dat_i, wb_sel_i);
    assign wr_cap_hdr = spbc_merge(cap_hdr_word, wb_dat_i, wb_sel_i);
    assign wr_dev_cap = spbc_merge(dev_cap_word, wb_dat_i, wb_sel_i);
    assign wr_lock    = spbc_merge(lock_word, wb_dat_i, wb_sel_i);
    assign wr_status  = spbc_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always @* begin
        video_fwd_next         = video_fwd_reg;
        video_wide_next        = video_wide_reg;
        sbr_next               = sbr_reg;
        next_ptr_next          = next_ptr_reg;
        cap_ver_next           = cap_ver_reg;
        slot_next              = slot_reg;
        max_payload_next       = max_payload_reg;
        ext_tag_next           = ext_tag_reg;
        lock_open_next         = lock_open_reg;
        unmapped_seen_next     = unmapped_seen_reg;
        locked_write_seen_next = locked_write_seen_reg;

        if (bus_wr && sel_bridge) begin
            video_fwd_next  = wr_bridge[`SPBC_BC_VIDEO_FWD];
            video_wide_next = wr_bridge[`SPBC_BC_VIDEO_WIDE];
            sbr_next        = wr_bridge[`SPBC_BC_SBR];
        end

        if (bus_wr && sel_cap_hdr) begin
            if (lock_open_reg) begin
                next_ptr_next = wr_cap_hdr[`SPBC_CH_NXT_LSB +: 8];
                cap_ver_next  = wr_cap_hdr[`SPBC_CH_VER_LSB +: 4];
                // the upstream link never has a slot, so the bit stays zero there
                slot_next     = (UPSTREAM == 0) & wr_cap_hdr[`SPBC_CH_SLOT];
            end
        end

        if (bus_wr && sel_dev_cap) begin
            if (lock_open_reg) begin
                max_payload_next = wr_dev_cap[`SPBC_DC_MPS_LSB +: 3];
                ext_tag_next     = wr_dev_cap[`SPBC_DC_EXTENDED_TAG_SUPPORT];
            end
        end

        if (bus_wr && sel_lock) begin
            lock_open_next = wr_lock[`SPBC_LK_OPEN];
        end

        // sticky flags: write one to clear, a new event in the same cycle wins
        if (bus_wr && sel_status) begin
            if (wr_status[`SPBC_ST_UNMAPPED]) begin
                unmapped_seen_next = 1'b0;
            end
            if (wr_status[`SPBC_ST_LOCKED_WR]) begin
                locked_write_seen_next = 1'b0;
            end
        end
        if (bus_req && !sel_any) begin
            unmapped_seen_next = 1'b1;
        end
        if (bus_wr && !lock_open_reg && (sel_cap_hdr || sel_dev_cap)) begin
            locked_write_seen_next = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            video_fwd_reg         <= 1'b0;
            video_wide_reg        <= 1'b0;
            sbr_reg               <= 1'b0;
            next_ptr_reg          <= `SPBC_NXT_PTR_RST;
            cap_ver_reg           <= `SPBC_VER_RST;
            slot_reg              <= 1'b0;
            max_payload_reg       <= `SPBC_MPS_RST;
            ext_tag_reg           <= `SPBC_EXTENDED_TAG_SUPPORT_RST;
            lock_open_reg         <= 1'b0;
            unmapped_seen_reg     <= 1'b0;
            locked_write_seen_reg <= 1'b0;
        end else begin
            video_fwd_reg         <= video_fwd_next;
            video_wide_reg        <= video_wide_next;
            sbr_reg               <= sbr_next;
            next_ptr_reg          <= next_ptr_next;
            cap_ver_reg           <= cap_ver_next;
            slot_reg              <= slot_next;
            max_payload_reg       <= max_payload_next;
            ext_tag_reg           <= ext_tag_next;
            lock_open_reg         <= lock_open_next;
            unmapped_seen_reg     <= unmapped_seen_next;
            locked_write_seen_reg <= locked_write_seen_next;
        end
    end

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------
    // read data shows the image of a read access; a write access returns zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                case (1'b1)
                    sel_bridge:  wb_dat_o <= bridge_word;
                    sel_cap_hdr: wb_dat_o <= cap_hdr_word;
                    sel_dev_cap: wb_dat_o <= dev_cap_word;
                    sel_lock:    wb_dat_o <= lock_word;
                    sel_status:  wb_dat_o <= status_word;
                    default:     wb_dat_o <= 32'h0000_0000;
                endcase
            end else if (bus_req) begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------------
    wire video_hit;
    wire video_hit_valid;
    wire sbr_up;
    wire sbr_down;
    wire sbr_start;

    spbc_video_decode u_video (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .fwd_en_i    (video_fwd_reg),
        .wide_en_i   (video_wide_reg),
        .req_valid_i (req_valid_i),
        .req_is_io_i (req_is_io_i),
        .req_addr_i  (req_addr_i),
        .hit_o       (video_hit),
        .hit_valid_o (video_hit_valid)
    );

    // software must not retune the port while this runs; nothing here enforces it
    spbc_sbr_trigger #(
        .UPSTREAM (UPSTREAM)
    ) u_sbr (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .sbr_bit_i   (sbr_reg),
        .sbr_up_o    (sbr_up),
        .sbr_down_o  (sbr_down),
        .sbr_start_o (sbr_start)
    );

    // one more flop so every top output comes straight from a register
    always @(posedge clk_i) begin
        if (rst_i) begin
            video_hit_o                <= 1'b0;
            video_hit_valid_o          <= 1'b0;
            legacy_video_forward_o     <= 1'b0;
            legacy_video_wide_decode_o <= 1'b0;
            sbr_upstream_o             <= 1'b0;
            sbr_downstream_o           <= 1'b0;
            sbr_start_o                <= 1'b0;
        end else begin
            video_hit_o                <= video_hit;
            video_hit_valid_o          <= video_hit_valid;
            legacy_video_forward_o     <= video_fwd_reg;
            legacy_video_wide_decode_o <= video_fwd_reg & video_wide_reg;
            sbr_upstream_o             <= sbr_up;
            sbr_downstream_o           <= sbr_down;
            sbr_start_o                <= sbr_start;
        end
    end
endmodule

// ==== common/spbc_map.vh ====
// Purpose: offsets, field positions, reset values for the switch port bridge control
//          and express capability register bank
// Assumes: 32-bit classic wishbone, word aligned registers, byte address = offset
// Notes:   included by the register and video decode design files of the block, not by the reset trigger
// Operation
// - legacy video forward bit 3 set forwards video addresses, clear blocks them
// - bit 4 picks 10-bit aliased or 16-bit video I/O decode, only while forwarding
// - setting bit 6 starts secondary bus reset, upstream or downstream variant by port
// - capability header bits 7:0 read fixed 0x10
// - header bits 15:8 next pointer, reset 0xC0, lock-writable
// - header bits 19:16 version, reset 0x2, lock-writable
// - header bits 23:20 read-only port type, 0x5 upstream, 0x6 downstream
// - header bit 24 marks slot; upstream port keeps it zero
// - header bits 29:25 interrupt message number read zero
// - device capabilities bits 2:0 max payload, default 0x4 (2048 bytes)
// - device capabilities bits 4:3 phantom functions hardwired zero
// - device capabilities bit 5 extended tag, reset 0x1, lock-writable
// - latency fields bits 8:6 and 11:9 hardwired zero
// - bits 12, 13, 14 legacy indicator flags read zero
// - bit 15 role based error support reads fixed 1
`ifndef SPBC_MAP_VH
`define SPBC_MAP_VH

// register byte offsets
`define SPBC_ADR_CAP_HDR        8'h40
`define SPBC_ADR_DEV_CAP        8'h44
`define SPBC_ADR_BRIDGE         8'h80
`define SPBC_ADR_LOCK           8'h84
`define SPBC_ADR_STATUS         8'h88

// bridge control upper fields
`define SPBC_BC_VIDEO_FWD       3
`define SPBC_BC_VIDEO_WIDE      4
`define SPBC_BC_SBR             6

// capability header fields
`define SPBC_CH_ID_LSB          0
`define SPBC_CH_NXT_LSB         8
`define SPBC_CH_VER_LSB         16
`define SPBC_CH_TYPE_LSB        20
`define SPBC_CH_SLOT            24
`define SPBC_CAP_ID             8'h10
`define SPBC_NXT_PTR_RST        8'hC0
`define SPBC_VER_RST            4'h2
`define SPBC_TYPE_UP            4'h5
`define SPBC_TYPE_DOWN          4'h6

// device capabilities fields
`define SPBC_DC_MPS_LSB         0
`define SPBC_DC_EXTENDED_TAG_SUPPORT            5
`define SPBC_DC_ROLE_BASED_ERROR_SUPPORT           15
`define SPBC_MPS_RST            3'h4
`define SPBC_EXTENDED_TAG_SUPPORT_RST           1'b1

// lock and status fields
`define SPBC_LK_OPEN            0
`define SPBC_ST_SBR             0
`define SPBC_ST_UPSTREAM        1
`define SPBC_ST_LOCK_OPEN       2
`define SPBC_ST_UNMAPPED        3
`define SPBC_ST_LOCKED_WR       4

// legacy video decode windows
`define SPBC_VMEM_LO            32'h000A_0000
`define SPBC_VMEM_HI            32'h000B_FFFF
`define SPBC_VIO_A_LO           10'h3B0
`define SPBC_VIO_A_HI           10'h3BB
`define SPBC_VIO_B_LO           10'h3C0
`define SPBC_VIO_B_HI           10'h3DF

`endif

// ==== rtl/spbc_video_decode.v ====
// Purpose: decides whether a primary side request hits the legacy video ranges
// Assumes: request fields are stable in the cycle req_valid_i is high
// Notes:   result is registered, one cycle after the request
`timescale 1ns/1ps
`include "spbc_map.vh"
module spbc_video_decode (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        fwd_en_i,
    input  wire        wide_en_i,
    input  wire        req_valid_i,
    input  wire        req_is_io_i,
    input  wire [31:0] req_addr_i,
    output reg         hit_o,
    output reg         hit_valid_o
);
    wire io_lo_match;
    wire io_hi_ok;
    wire mem_match;
    assign io_lo_match = ((req_addr_i[9:0] >= `SPBC_VIO_A_LO) && (req_addr_i[9:0] <= `SPBC_VIO_A_HI)) ||
                         ((req_addr_i[9:0] >= `SPBC_VIO_B_LO) && (req_addr_i[9:0] <= `SPBC_VIO_B_HI));
    // 10-bit mode ignores upper bits so every 1 KB alias hits
    assign io_hi_ok    = ~wide_en_i | (req_addr_i[15:10] == 6'h00);
    assign mem_match   = (req_addr_i >= `SPBC_VMEM_LO) && (req_addr_i <= `SPBC_VMEM_HI);

    always @(posedge clk_i) begin
        if (rst_i) begin
            hit_o       <= 1'b0;
            hit_valid_o <= 1'b0;
        end else begin
            hit_valid_o <= req_valid_i;
            if (req_valid_i) begin
                // forwarding off blocks everything, width bit then has no effect
                hit_o <= fwd_en_i & (req_is_io_i ? (io_lo_match & io_hi_ok) : mem_match);
            end
        end
    end
endmodule

// ==== rtl/spbc_sbr_trigger.v ====
// Purpose: turns the secondary bus reset bit into the port's reset request
// Assumes: UPSTREAM fixed per port instance
// Notes:   level follows the bit, start pulses one cycle on the rising edge
`timescale 1ns/1ps
module spbc_sbr_trigger #(
    parameter UPSTREAM = 0
) (
    input  wire clk_i,
    input  wire rst_i,
    input  wire sbr_bit_i,
    output reg  sbr_up_o,
    output reg  sbr_down_o,
    output reg  sbr_start_o
);
    reg sbr_seen_reg;
    always @(posedge clk_i) begin
        if (rst_i) begin
            sbr_seen_reg <= 1'b0;
            sbr_up_o     <= 1'b0;
            sbr_down_o   <= 1'b0;
            sbr_start_o  <= 1'b0;
        end else begin
            sbr_seen_reg <= sbr_bit_i;
            sbr_up_o     <= (UPSTREAM != 0) & sbr_bit_i;
            sbr_down_o   <= (UPSTREAM == 0) & sbr_bit_i;
            sbr_start_o  <= sbr_bit_i & ~sbr_seen_reg;
        end
    end
endmodule

// ==== test/spbc_regs_chk.sv ====
// Purpose: concurrent checks on the register bank ports
// Assumes: classic wishbone master, one clock, synchronous reset
// Notes:   port type and reset direction follow UPSTREAM
`timescale 1ns/1ps
`include "spbc_map.vh"
module spbc_regs_chk #(
    parameter UPSTREAM = 0,
    parameter AW       = 8
) (
    input wire          clk_i,
    input wire          rst_i,
    input wire          wb_cyc_i,
    input wire          wb_stb_i,
    input wire          wb_we_i,
    input wire [AW-1:0] wb_adr_i,
    input wire [3:0]    wb_sel_i,
    input wire [31:0]   wb_dat_i,
    input wire [31:0]   wb_dat_o,
    input wire          wb_ack_o,
    input wire          req_valid_i,
    input wire          req_is_io_i,
    input wire [31:0]   req_addr_i,
    input wire          video_hit_o,
    input wire          video_hit_valid_o,
    input wire          legacy_video_forward_o,
    input wire          legacy_video_wide_decode_o,
    input wire          sbr_upstream_o,
    input wire          sbr_downstream_o,
    input wire          sbr_start_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire rd    = wb_ack_o && !wb_we_i;
    wire wr_br = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `SPBC_ADR_BRIDGE && wb_sel_i[0];
    wire own   = UPSTREAM ? sbr_upstream_o : sbr_downstream_o;
    wire other = UPSTREAM ? sbr_downstream_o : sbr_upstream_o;
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("access not acked in the next cycle");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_HDR: assert property (rd && wb_adr_i == `SPBC_ADR_CAP_HDR |-> wb_dat_o[7:0] == `SPBC_CAP_ID
        && wb_dat_o[23:20] == (UPSTREAM ? `SPBC_TYPE_UP : `SPBC_TYPE_DOWN) && wb_dat_o[31:25] == 7'h0)
        else $error("capability header fixed fields wrong");
    AST_DCAP: assert property (rd && wb_adr_i == `SPBC_ADR_DEV_CAP |-> wb_dat_o[4:3] == 2'h0
        && wb_dat_o[14:6] == 9'h0 && wb_dat_o[15] && wb_dat_o[31:16] == 16'h0)
        else $error("device capabilities fixed fields wrong");
    AST_BRIDGE_CONTROL_UPPER: assert property (rd && wb_adr_i == `SPBC_ADR_BRIDGE |-> (wb_dat_o & 32'hFFFF_FFA7) == 32'h0)
        else $error("bridge control reserved bits not zero");
    AST_FWD: assert property (wr_br |-> ##2 legacy_video_forward_o == $past(wb_dat_i[3], 2)
        && legacy_video_wide_decode_o == ($past(wb_dat_i[4], 2) && $past(wb_dat_i[3], 2)))
        else $error("video forward outputs do not follow the write");
    AST_SBR: assert property (wr_br && wb_dat_i[6] |-> ##3 own && !other)
        else $error("secondary reset not raised on the right port");
    AST_START: assert property (sbr_start_o |-> $rose(own) ##1 !sbr_start_o)
        else $error("reset start pulse out of step with the level");
    AST_VIDEO: assert property (req_valid_i |-> ##2 video_hit_valid_o)
        else $error("video decode result late");
    AST_BLOCK: assert property (video_hit_valid_o && !$past(legacy_video_forward_o) |-> !video_hit_o)
        else $error("video hit while forwarding is off");
    cover property (wr_br && wb_dat_i[6]);
    cover property (video_hit_valid_o && video_hit_o);
    cover property (rd && wb_adr_i == `SPBC_ADR_CAP_HDR);
endmodule
bind spbc_regs spbc_regs_chk #(.UPSTREAM(UPSTREAM), .AW(AW)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
    .req_is_io_i(req_is_io_i), .req_addr_i(req_addr_i), .video_hit_o(video_hit_o),
    .video_hit_valid_o(video_hit_valid_o), .legacy_video_forward_o(legacy_video_forward_o),
    .legacy_video_wide_decode_o(legacy_video_wide_decode_o), .sbr_upstream_o(sbr_upstream_o),
    .sbr_downstream_o(sbr_downstream_o), .sbr_start_o(sbr_start_o));

// ==== test/spbc_regs_tb_top.sv ====
// Purpose: directed register and video decode tests of a downstream port, upstream twin on the same bus
// Assumes: one clock at 200 MHz, synchronous active high reset
// Notes:   waits on ack are ended only by the cycle ceiling
`timescale 1ns/1ps
`include "spbc_map.vh"
module spbc_regs_tb_top;
    reg         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i, req_is_io_i;
    reg  [7:0]  wb_adr_i;
    reg  [3:0]  wb_sel_i;
    reg  [31:0] wb_dat_i, req_addr_i, q_up;
    wire [31:0] wb_dat_o, up_dat;
    wire        wb_ack_o, video_hit_o, video_hit_valid_o, fwd_o, wide_o, up_o, down_o, start_o, up_up, up_down;
    integer     n_errors = 0;
    integer     n_starts = 0;
    integer     total_checks = 0;
    integer     cycles = 0;
    spbc_regs #(.UPSTREAM(0), .AW(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
        .req_is_io_i(req_is_io_i), .req_addr_i(req_addr_i), .video_hit_o(video_hit_o),
        .video_hit_valid_o(video_hit_valid_o), .legacy_video_forward_o(fwd_o),
        .legacy_video_wide_decode_o(wide_o), .sbr_upstream_o(up_o), .sbr_downstream_o(down_o),
        .sbr_start_o(start_o));
    spbc_regs #(.UPSTREAM(1), .AW(8)) dut_up (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(up_dat), .wb_ack_o(), .req_valid_i(req_valid_i),
        .req_is_io_i(req_is_io_i), .req_addr_i(req_addr_i), .video_hit_o(), .video_hit_valid_o(),
        .legacy_video_forward_o(), .legacy_video_wide_decode_o(), .sbr_upstream_o(up_up),
        .sbr_downstream_o(up_down), .sbr_start_o());
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task wrap_up;
        begin
            $display("checks %0d errors %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // the ceiling is generous: the whole sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (start_o === 1'b1) n_starts <= n_starts + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            wrap_up;
        end
    end
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task wb(input w, input [7:0] a, input [3:0] s, input [31:0] d, output [31:0] q);
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i  <= w;
            wb_adr_i <= a;
            wb_sel_i <= s;
            wb_dat_i <= d;
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1) @(posedge clk_i);
            q = wb_dat_o;
            q_up = up_dat;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [3:0] s, input [31:0] d);
        reg [31:0] q;
        wb(1'b1, a, s, d, q);
    endtask
    task rc(input string nm, input [7:0] a, input [31:0] e);
        reg [31:0] q;
        begin
            wb(1'b0, a, 4'hF, 32'h0, q);
            check(nm, q, e);
        end
    endtask
    task vr(input io, input [31:0] a, input e);
        begin
            @(posedge clk_i);
            req_valid_i <= 1'b1;
            req_is_io_i <= io;
            req_addr_i  <= a;
            @(posedge clk_i);
            req_valid_i <= 1'b0;
            @(posedge clk_i);
            #1;
            check("video_hit", {video_hit_valid_o, video_hit_o}, {1'b1, e});
        end
    endtask
    // outputs lag the bridge write by up to three cycles
    task lv(input [3:0] e);
        begin
            repeat (3) @(posedge clk_i);
            #1;
            check("bridge_outputs", {fwd_o, wide_o, up_o, down_o}, e);
            check("bridge_up", {up_up, up_down}, {e[0], 1'b0});
        end
    endtask
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, req_valid_i, req_is_io_i} = 5'h0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        req_addr_i = 32'h0;
        rst_i = 1'b1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rc("cap_hdr", `SPBC_ADR_CAP_HDR, 32'h0062_C010);
        check("cap_hdr_up", q_up, 32'h0052_C010);
        rc("dev_cap", `SPBC_ADR_DEV_CAP, 32'h0000_8024);
        rc("bridge", `SPBC_ADR_BRIDGE, 32'h0000_0000);
        wr(`SPBC_ADR_CAP_HDR, 4'hF, 32'hFFFF_FFFF);
        rc("cap_hdr_locked", `SPBC_ADR_CAP_HDR, 32'h0062_C010);
        rc("unmapped", 8'h90, 32'h0000_0000);
        rc("status", `SPBC_ADR_STATUS, 32'h0000_0018);
        wr(`SPBC_ADR_LOCK, 4'h1, 32'h0000_0001);
        wr(`SPBC_ADR_CAP_HDR, 4'hF, 32'hFFFF_FFFF);
        rc("cap_hdr_open", `SPBC_ADR_CAP_HDR, 32'h016F_FF10);
        check("cap_hdr_up_open", q_up, 32'h005F_FF10);
        wr(`SPBC_ADR_CAP_HDR, 4'h2, 32'h0000_AB00);
        rc("cap_hdr_lane", `SPBC_ADR_CAP_HDR, 32'h016F_AB10);
        wr(`SPBC_ADR_DEV_CAP, 4'hF, 32'hFFFF_FFFF);
        rc("dev_cap_ones", `SPBC_ADR_DEV_CAP, 32'h0000_8027);
        wr(`SPBC_ADR_DEV_CAP, 4'hF, 32'h0000_0000);
        rc("dev_cap_zero", `SPBC_ADR_DEV_CAP, 32'h0000_8000);
        wr(`SPBC_ADR_LOCK, 4'h1, 32'h0000_0000);
        wr(`SPBC_ADR_DEV_CAP, 4'hF, 32'hFFFF_FFFF);
        rc("dev_cap_relock", `SPBC_ADR_DEV_CAP, 32'h0000_8000);
        vr(1'b0, 32'h000A_0000, 1'b0);
        wr(`SPBC_ADR_BRIDGE, 4'hF, 32'hFFFF_FFFF);
        rc("bridge_ones", `SPBC_ADR_BRIDGE, 32'h0000_0058);
        lv(4'b1101);
        vr(1'b1, 32'h0000_07B0, 1'b0);
        vr(1'b1, 32'h0000_03C4, 1'b1);
        wr(`SPBC_ADR_BRIDGE, 4'h1, 32'h0000_0008);
        lv(4'b1000);
        vr(1'b1, 32'h0000_07B0, 1'b1);
        vr(1'b0, 32'h000B_FFFF, 1'b1);
        vr(1'b0, 32'h000C_0000, 1'b0);
        wr(`SPBC_ADR_BRIDGE, 4'h1, 32'h0000_0010);
        lv(4'b0000);
        vr(1'b1, 32'h0000_03B0, 1'b0);
        check("sbr_starts", n_starts, 32'h0000_0001);
        wrap_up;
    end
endmodule
